// ---- src/dsm_cfg.svh ----
// offsets, field positions, reset values and codes of the drive objects
`ifndef DSM_CFG_SVH
`define DSM_CFG_SVH

// ----------------------------------------
// object indices and sub-indices
// ----------------------------------------
`define DSM_IDX_STATE_WORD     16'h6041
`define DSM_IDX_MODE_REQUEST   16'h6060
`define DSM_IDX_MODE_DISPLAY   16'h6061
`define DSM_IDX_RESOLUTION     16'h608F
`define DSM_IDX_GEAR           16'h6091
`define DSM_IDX_SUPPORTED      16'h6502
`define DSM_SUB_COUNT          8'h00
`define DSM_SUB_FIRST          8'h01
`define DSM_SUB_SECOND         8'h02

// ----------------------------------------
// reset and constant values
// ----------------------------------------
`define DSM_ENTRY_COUNT        8'h02
`define DSM_UNIT_RESET         32'h0000_00FF
`define DSM_TURNS_RESET        32'h0000_0001
`define DSM_SUPPORTED_MASK     32'h0000_000D
`define DSM_MODE_RESET         8'h01

// ----------------------------------------
// mode codes and unit codes
// ----------------------------------------
`define DSM_MODE_POSITION      8'h01
`define DSM_MODE_VELOCITY      8'h03
`define DSM_MODE_TORQUE        8'h04
`define DSM_UNIT_DEGREES       32'h0000_0041
`define DSM_UNIT_MINUTES       32'h0000_0042
`define DSM_UNIT_SECONDS       32'h0000_0043
`define DSM_UNIT_INTERNAL      32'h0000_00FF

// ----------------------------------------
// state word bit positions and the control word fault reset bit
// ----------------------------------------
`define DSM_SW_VOLTAGE         4
`define DSM_SW_QUICK_STOP      5
`define DSM_SW_DISABLED        6
`define DSM_SW_WARNING         7
`define DSM_SW_REMOTE          9
`define DSM_SW_TARGET          10
`define DSM_SW_LIMIT           11
`define DSM_SW_MODE_LO         12
`define DSM_CW_FAULT_RESET     7

// ----------------------------------------
// abort codes of the service channel
// ----------------------------------------
`define DSM_ABORT_NO_OBJECT    32'h0602_0000
`define DSM_ABORT_NO_SUB       32'h0609_0011
`define DSM_ABORT_READ_ONLY    32'h0601_0002
`define DSM_ABORT_RANGE        32'h0609_0030

`endif

// ---- src/dsm_pkg.sv ----
// types shared by the drive status and mode object logic
package dsm_pkg;

   // drive state machine states, supplied by the control word logic
   typedef enum logic [2:0] {
      DSM_NOT_READY,
      DSM_SWITCH_ON_DISABLED,
      DSM_READY_TO_SWITCH_ON,
      DSM_SWITCHED_ON,
      DSM_OPERATION_ENABLED,
      DSM_QUICK_STOP_ACTIVE,
      DSM_FAULT_REACTION,
      DSM_FAULT
   } dsm_drive_state_t;

   // condition flags feeding the state word
   typedef struct packed {
      logic       power_supplied;
      logic       at_reference;
      logic       halt_active;
      logic [1:0] mode_bits;
   } dsm_cond_t;

   // object access request from the network side
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] index;
      logic [7:0]  subidx;
      logic [31:0] wdata;
   } dsm_obj_req_t;

   // object access answer
   typedef struct packed {
      logic        ack;
      logic        abort;
      logic [31:0] abort_code;
      logic [31:0] rdata;
   } dsm_obj_rsp_t;

endpackage

// ---- src/dsm_state_word.sv ----
// builds the 16-bit drive state word from state and condition flags
`timescale 1ns/10ps
`default_nettype none
`include "dsm_cfg.svh"

module dsm_state_word (
   input  wire dsm_pkg::dsm_drive_state_t state,
   input  wire dsm_pkg::dsm_cond_t        cond,
   input  wire logic                      remote,
   output logic [15:0]                    word
);

   // ----------------------------------------
   // state bits 6,5 and 3..0
   // ----------------------------------------
   function automatic logic [6:0] dsm_state_bits(input dsm_pkg::dsm_drive_state_t s);
      case (s)
         dsm_pkg::DSM_NOT_READY:          dsm_state_bits = 7'b000_0000;
         dsm_pkg::DSM_SWITCH_ON_DISABLED: dsm_state_bits = 7'b100_0000;
         dsm_pkg::DSM_READY_TO_SWITCH_ON: dsm_state_bits = 7'b010_0001;
         dsm_pkg::DSM_SWITCHED_ON:        dsm_state_bits = 7'b010_0011;
         dsm_pkg::DSM_OPERATION_ENABLED:  dsm_state_bits = 7'b010_0111;
         dsm_pkg::DSM_QUICK_STOP_ACTIVE:  dsm_state_bits = 7'b000_0111;
         dsm_pkg::DSM_FAULT_REACTION:     dsm_state_bits = 7'b000_1111;
         dsm_pkg::DSM_FAULT:              dsm_state_bits = 7'b000_1000;
         default:                         dsm_state_bits = 7'b000_0000;
      endcase
   endfunction

   // ----------------------------------------
   // word assembly
   // ----------------------------------------
   always_comb begin
      word                      = 16'h0000; // warning, limit, reserved low
      word[6:0]                 = dsm_state_bits(state);
      word[`DSM_SW_VOLTAGE]     = cond.power_supplied;
      word[`DSM_SW_REMOTE]      = remote;
      word[`DSM_SW_TARGET]      = cond.at_reference | cond.halt_active
                                | (state == dsm_pkg::DSM_QUICK_STOP_ACTIVE);
      word[`DSM_SW_MODE_LO+1:`DSM_SW_MODE_LO] = cond.mode_bits;
   end

endmodule
`default_nettype wire

// ---- src/dsm_value_check.sv ----
// decides whether a written value lies in an object's accepted set
`timescale 1ns/10ps
`default_nettype none
`include "dsm_cfg.svh"

module dsm_value_check (
   input  wire logic [15:0] index,
   input  wire logic [7:0]  subidx,
   input  wire logic [31:0] wdata,
   output logic             value_ok
);

   // ----------------------------------------
   // accepted value sets
   // ----------------------------------------
   always_comb begin
      value_ok = 1'b0;
      case (index)
         `DSM_IDX_MODE_REQUEST:
            value_ok = (wdata[7:0] == `DSM_MODE_POSITION)
                     | (wdata[7:0] == `DSM_MODE_VELOCITY)
                     | (wdata[7:0] == `DSM_MODE_TORQUE);
         `DSM_IDX_RESOLUTION: begin
            if (subidx == `DSM_SUB_FIRST) begin
               value_ok = (wdata == `DSM_UNIT_DEGREES) | (wdata == `DSM_UNIT_MINUTES)
                        | (wdata == `DSM_UNIT_SECONDS) | (wdata == `DSM_UNIT_INTERNAL);
            end else begin
               value_ok = (wdata == `DSM_TURNS_RESET);
            end
         end
         `DSM_IDX_GEAR:
            value_ok = (wdata == `DSM_TURNS_RESET);
         default:
            value_ok = 1'b0;
      endcase
   end

endmodule
`default_nettype wire

// ---- src/dsm_drive_objects.sv ----
// drive state word, mode and unit-conversion objects of the drive profile
//
// Overview of operation
// - not ready 0000, disabled 0000 with bit6
// - ready/on/enabled: bit5 set, 0001/0011/0111
// - quick stop 00x0111, fault react 1111, fault 1000
// - bit 4 high while power section fed
// - bit 9 set in remote network mode
// - bit 10 at reference, quick stop, halt
// - warning and internal limit bits stay low
// - bits 12-13 mode specific, others reserved
// - commands run only under network mode source
// - mode request accepts 1, 3, 4 only
// - mode display shows mode in effect
// - supported modes read-only constant 0Dh
// - increments unit accepts 41,42,43,FF
// - resolution motor turns accepts only 1
// - both gear sub-entries accept only 1
// - sub-entry 0 of arrays reads 02h
// - state word read-only, tracks state machine
`timescale 1ns/10ps
`default_nettype none
`include "dsm_cfg.svh"

module dsm_drive_objects (
   input  wire logic                      clk_sys,
   input  wire logic                      rst_b,
   input  wire dsm_pkg::dsm_obj_req_t     obj_req,
   output dsm_pkg::dsm_obj_rsp_t          obj_rsp,
   input  wire dsm_pkg::dsm_drive_state_t drive_state,
   input  wire dsm_pkg::dsm_cond_t        drive_cond,
   input  wire logic                      mode_source_parameter,
   input  wire logic                      ctrl_valid,
   input  wire logic [15:0]               ctrl_word,
   output logic                           cmd_valid,
   output logic [15:0]                    cmd_word,
   output logic                           cmd_refused,
   output logic                           fault_reset_pulse,
   output logic [15:0]                    state_word,
   output logic [7:0]                     mode_active,
   output logic [31:0]                    increments_unit,
   output logic [31:0]                    resolution_turns,
   output logic [31:0]                    gear_motor_turns,
   output logic [31:0]                    gear_shaft_turns
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [15:0]               state_word_next;
   logic                      value_ok;
   logic                      obj_known;
   logic                      sub_known;
   logic                      obj_writable;
   logic                      wr_accept;
   logic [31:0]               rdata_next;
   logic [31:0]               abort_next;
   logic                      abort_flag_next;
   logic [7:0]                mode_request_reg;
   logic [7:0]                mode_active_reg;
   logic [31:0]               unit_reg;
   logic [31:0]               res_turns_reg;
   logic [31:0]               gear_motor_reg;
   logic [31:0]               gear_shaft_reg;
   logic [15:0]               state_word_reg;
   logic                      fault_bit_reg;
   dsm_pkg::dsm_obj_rsp_t     rsp_reg;
   logic                      cmd_valid_reg;
   logic [15:0]               cmd_word_reg;
   logic                      cmd_refused_reg;
   logic                      fault_reset_reg;

   // ----------------------------------------
   // object decode helpers
   // ----------------------------------------
   // true for an index that this block answers
   function automatic logic dsm_is_object(input logic [15:0] idx);
      case (idx)
         `DSM_IDX_STATE_WORD,
         `DSM_IDX_MODE_REQUEST,
         `DSM_IDX_MODE_DISPLAY,
         `DSM_IDX_RESOLUTION,
         `DSM_IDX_GEAR,
         `DSM_IDX_SUPPORTED: dsm_is_object = 1'b1;
         default:            dsm_is_object = 1'b0;
      endcase
   endfunction

   // true for an array object with three sub-entries
   function automatic logic dsm_is_array(input logic [15:0] idx);
      dsm_is_array = (idx == `DSM_IDX_RESOLUTION) || (idx == `DSM_IDX_GEAR);
   endfunction

   // true for a valid sub-index of a known object
   function automatic logic dsm_sub_ok(input logic [15:0] idx, input logic [7:0] sub);
      if (dsm_is_array(idx)) begin
         dsm_sub_ok = (sub <= `DSM_SUB_SECOND);
      end else begin
         dsm_sub_ok = (sub == `DSM_SUB_COUNT);
      end
   endfunction

   // true where a write may store, sub-entry 0 of arrays never
   function automatic logic dsm_is_writable(input logic [15:0] idx, input logic [7:0] sub);
      if (dsm_is_array(idx)) begin
         dsm_is_writable = (sub != `DSM_SUB_COUNT);
      end else begin
         dsm_is_writable = (idx == `DSM_IDX_MODE_REQUEST);
      end
   endfunction

   // ----------------------------------------
   // sub-blocks
   // ----------------------------------------
   dsm_state_word u_state_word (
      .state  (drive_state),
      .cond   (drive_cond),
      .remote (mode_source_parameter),
      .word   (state_word_next)
   );

   dsm_value_check u_value_check (
      .index    (obj_req.index),
      .subidx   (obj_req.subidx),
      .wdata    (obj_req.wdata),
      .value_ok (value_ok)
   );

   // ----------------------------------------
   // access classification
   // ----------------------------------------
   // a write stores only when object, sub-entry, access and value all pass
   always_comb begin
      obj_known    = dsm_is_object(obj_req.index);
      sub_known    = obj_known && dsm_sub_ok(obj_req.index, obj_req.subidx);
      obj_writable = sub_known && dsm_is_writable(obj_req.index, obj_req.subidx);
      wr_accept    = obj_req.valid && obj_req.write && obj_writable && value_ok;
   end

   // ----------------------------------------
   // read data selection
   // ----------------------------------------
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (obj_req.index)
         `DSM_IDX_STATE_WORD:
            rdata_next = {16'h0000, state_word_reg};
         `DSM_IDX_MODE_REQUEST:
            rdata_next = {24'h00_0000, mode_request_reg};
         `DSM_IDX_MODE_DISPLAY:
            rdata_next = {24'h00_0000, mode_active_reg};
         `DSM_IDX_SUPPORTED:
            rdata_next = `DSM_SUPPORTED_MASK;
         `DSM_IDX_RESOLUTION: begin
            case (obj_req.subidx)
               `DSM_SUB_COUNT:  rdata_next = {24'h00_0000, `DSM_ENTRY_COUNT};
               `DSM_SUB_FIRST:  rdata_next = unit_reg;
               default:         rdata_next = res_turns_reg;
            endcase
         end
         `DSM_IDX_GEAR: begin
            case (obj_req.subidx)
               `DSM_SUB_COUNT:  rdata_next = {24'h00_0000, `DSM_ENTRY_COUNT};
               `DSM_SUB_FIRST:  rdata_next = gear_motor_reg;
               default:         rdata_next = gear_shaft_reg;
            endcase
         end
         default:
            rdata_next = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------
   // abort cause, in order of precedence
   // ----------------------------------------
   always_comb begin
      abort_flag_next = 1'b1;
      abort_next      = 32'h0000_0000;
      if (!obj_known) begin
         abort_next = `DSM_ABORT_NO_OBJECT;
      end else if (!sub_known) begin
         abort_next = `DSM_ABORT_NO_SUB;
      end else if (obj_req.write && !obj_writable) begin
         abort_next = `DSM_ABORT_READ_ONLY;
      end else if (obj_req.write && !value_ok) begin
         abort_next = `DSM_ABORT_RANGE;
      end else begin
         abort_flag_next = 1'b0;
      end
   end

   // ----------------------------------------
   // access answer, one cycle after the request
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rsp_reg <= '0;
      end else begin
         rsp_reg.ack        <= obj_req.valid;
         rsp_reg.abort      <= obj_req.valid && abort_flag_next;
         rsp_reg.abort_code <= (obj_req.valid && abort_flag_next) ? abort_next : 32'h0000_0000;
         rsp_reg.rdata      <= (obj_req.valid && !obj_req.write && !abort_flag_next)
                               ? rdata_next : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // mode request and mode in effect
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         mode_request_reg <= `DSM_MODE_RESET;
      end else if (wr_accept && obj_req.index == `DSM_IDX_MODE_REQUEST) begin
         mode_request_reg <= obj_req.wdata[7:0];
      end
   end

   // requested mode takes effect on the next edge
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         mode_active_reg <= `DSM_MODE_RESET;
      end else begin
         mode_active_reg <= mode_request_reg;
      end
   end

   // ----------------------------------------
   // position encoder resolution entries
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         unit_reg      <= `DSM_UNIT_RESET;
         res_turns_reg <= `DSM_TURNS_RESET;
      end else if (wr_accept && obj_req.index == `DSM_IDX_RESOLUTION) begin
         if (obj_req.subidx == `DSM_SUB_FIRST) begin
            unit_reg <= obj_req.wdata;
         end else begin
            res_turns_reg <= obj_req.wdata;
         end
      end
   end

   // ----------------------------------------
   // gear ratio entries
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         gear_motor_reg <= `DSM_TURNS_RESET;
         gear_shaft_reg <= `DSM_TURNS_RESET;
      end else if (wr_accept && obj_req.index == `DSM_IDX_GEAR) begin
         if (obj_req.subidx == `DSM_SUB_FIRST) begin
            gear_motor_reg <= obj_req.wdata;
         end else begin
            gear_shaft_reg <= obj_req.wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // state word capture
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_word_reg <= 16'h0000;
      end else begin
         state_word_reg <= state_word_next;
      end
   end

   // ----------------------------------------------------------------
   // control word gate
   // ----------------------------------------------------------------
   // commands pass only while the mode source selects the network
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cmd_valid_reg   <= 1'b0;
         cmd_word_reg    <= 16'h0000;
         cmd_refused_reg <= 1'b0;
      end else begin
         cmd_valid_reg   <= ctrl_valid && mode_source_parameter;
         cmd_refused_reg <= ctrl_valid && !mode_source_parameter;
         if (ctrl_valid && mode_source_parameter) begin
            cmd_word_reg <= ctrl_word;
         end
      end
   end

   // ----------------------------------------------------------------
   // fault reset edge
   // ----------------------------------------------------------------
   // last accepted fault reset bit, edge seen only on accepted words
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         fault_bit_reg   <= 1'b0;
         fault_reset_reg <= 1'b0;
      end else begin
         fault_reset_reg <= 1'b0;
         if (ctrl_valid && mode_source_parameter) begin
            fault_bit_reg   <= ctrl_word[`DSM_CW_FAULT_RESET];
            fault_reset_reg <= ctrl_word[`DSM_CW_FAULT_RESET] && !fault_bit_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs, all from flip-flops
   // ----------------------------------------------------------------
   assign obj_rsp           = rsp_reg;
   assign cmd_valid         = cmd_valid_reg;
   assign cmd_word          = cmd_word_reg;
   assign cmd_refused       = cmd_refused_reg;
   assign fault_reset_pulse = fault_reset_reg;
   assign state_word        = state_word_reg;
   assign mode_active       = mode_active_reg;
   assign increments_unit   = unit_reg;
   assign resolution_turns  = res_turns_reg;
   assign gear_motor_turns  = gear_motor_reg;
   assign gear_shaft_turns  = gear_shaft_reg;

endmodule
`default_nettype wire

// ---- testbench/dsm_drive_objects_properties.sv ----
// concurrent checks on the drive object ports
`timescale 1ns/10ps
`default_nettype none
module dsm_drive_objects_properties (
   input wire logic                      clk_sys,
   input wire logic                      rst_b,
   input wire dsm_pkg::dsm_obj_req_t     obj_req,
   input wire dsm_pkg::dsm_obj_rsp_t     obj_rsp,
   input wire dsm_pkg::dsm_drive_state_t drive_state,
   input wire dsm_pkg::dsm_cond_t        drive_cond,
   input wire logic                      mode_source_parameter,
   input wire logic                      ctrl_valid,
   input wire logic                      cmd_valid,
   input wire logic                      cmd_refused,
   input wire logic [15:0]               state_word,
   input wire logic [7:0]                mode_active
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // bits 6,5,3..0 expected per drive state
   localparam logic [5:0] CODE [8] = '{6'h00, 6'h20, 6'h11, 6'h13, 6'h17, 6'h07, 6'h0F, 6'h08};
   wire logic tgt = drive_cond.at_reference || drive_cond.halt_active
                    || drive_state == dsm_pkg::DSM_QUICK_STOP_ACTIVE;
   wire logic mode_wr = obj_req.valid && obj_req.write && obj_req.index == 16'h6060
                        && obj_req.subidx == 8'h00;
   wire logic mode_ok = obj_req.wdata[7:0] inside {8'h01, 8'h03, 8'h04};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence s_mode_ok;
      mode_wr && mode_ok;
   endsequence
   sequence s_mode_bad;
      mode_wr && !mode_ok;
   endsequence
   sequence s_ack_clean;
      obj_rsp.ack && !obj_rsp.abort;
   endsequence
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_state_code: assert property ($past(rst_b) |->
      {state_word[6:5], state_word[3:0]} == CODE[$past(drive_state)]) else $error("state code");
   a_power_bit: assert property ($past(rst_b) |->
      state_word[4] == $past(drive_cond.power_supplied)) else $error("voltage bit");
   a_remote_bit: assert property ($past(rst_b) |->
      state_word[9] == $past(mode_source_parameter)) else $error("remote bit");
   a_target_bit: assert property ($past(rst_b) |->
      state_word[10] == $past(tgt)) else $error("target bit");
   a_unused_bits: assert property ((state_word & 16'hC980) == 16'h0000)
      else $error("unused bit set");
   a_mode_bits: assert property ($past(rst_b) |->
      state_word[13:12] == $past(drive_cond.mode_bits)) else $error("mode bits");
   a_mode_take: assert property (s_mode_ok |=> s_ack_clean ##1
      mode_active == $past(obj_req.wdata[7:0], 2)) else $error("mode not taken");
   a_mode_keep: assert property (s_mode_bad |=> obj_rsp.abort ##1
      $stable(mode_active)) else $error("bad mode taken");
   a_abort_code: assert property (obj_rsp.abort |->
      obj_rsp.ack && obj_rsp.abort_code != 32'h0) else $error("abort without code");
   a_supported: assert property (obj_req.valid && !obj_req.write
      && obj_req.index == 16'h6502 && obj_req.subidx == 8'h00 |=> obj_rsp.rdata == 32'h0000_000D)
      else $error("supported mask");
   a_cmd_gate: assert property (ctrl_valid |=> cmd_valid == $past(mode_source_parameter)
      && cmd_refused == !$past(mode_source_parameter)) else $error("command gate");
endmodule
bind dsm_drive_objects dsm_drive_objects_properties i_props (.clk_sys, .rst_b, .obj_req,
   .obj_rsp, .drive_state, .drive_cond, .mode_source_parameter, .ctrl_valid, .cmd_valid,
   .cmd_refused, .state_word, .mode_active);
`default_nettype wire

// ---- testbench/dsm_net_master.sv ----
// network master model: object accesses and control words
`timescale 1ns/10ps
`default_nettype none
module dsm_net_master (
   input  wire dsm_pkg::dsm_obj_rsp_t obj_rsp,
   input  wire logic                  clk_sys,
   output var dsm_pkg::dsm_obj_req_t  obj_req,
   output var logic                   ctrl_valid,
   output var logic [15:0]            ctrl_word,
   output var logic                   mode_source_parameter
);
   initial begin
      obj_req = '0;
      ctrl_valid = 1'b0;
      ctrl_word = 16'h0000;
      mode_source_parameter = 1'b0;
   end
   // one access, idle lines scrambled
   task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                         input logic [31:0] wd, output dsm_pkg::dsm_obj_rsp_t rsp);
      obj_req = {1'b1, wr, idx, sub, wd};
      @(posedge clk_sys);
      #1;
      rsp = obj_rsp;
      obj_req = {1'b0, ~wr, ~idx, ~sub, ~wd};
      @(posedge clk_sys);
      #1;
   endtask
   // mode source, set before commands
   task automatic set_source(input logic b);
      mode_source_parameter = b;
   endtask
   // control word pulse
   task automatic send(input logic [15:0] w);
      ctrl_word = w;
      ctrl_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      ctrl_valid = 1'b0;
      ctrl_word = ~w;
   endtask
endmodule
`default_nettype wire

// ---- testbench/dsm_drive_objects_bench.sv ----
// self-checking bench of the drive object logic
`timescale 1ns/10ps
`default_nettype none
`include "dsm_cfg.svh"
module dsm_drive_objects_bench;
   localparam logic [5:0]  CODE [8] = '{6'h00, 6'h20, 6'h11, 6'h13, 6'h17, 6'h07, 6'h0F, 6'h08};
   localparam logic [15:0] IX [9]   = '{16'h608F, 16'h608F, 16'h608F, 16'h6091, 16'h6091,
                                        16'h6091, 16'h6502, 16'h6060, 16'h6061};
   localparam logic [31:0] RV [9]   = '{32'h2, 32'hFF, 32'h1, 32'h2, 32'h1, 32'h1, 32'hD, 32'h1, 32'h1};
   localparam logic [31:0] UV [5]   = '{32'h41, 32'h42, 32'h43, 32'h44, 32'hFF};
   logic                      clk_sys, rst_b, ok, ctrl_valid, mode_source_parameter;
   logic                      cmd_valid, cmd_refused, fault_reset_pulse;
   logic [7:0]                last;
   logic [15:0]               ctrl_word, state_word, sw;
   dsm_pkg::dsm_obj_req_t     obj_req;
   dsm_pkg::dsm_obj_rsp_t     obj_rsp;
   dsm_pkg::dsm_drive_state_t drive_state;
   dsm_pkg::dsm_cond_t        drive_cond;
   int                        n_fail = 0;
   int                        n_checks = 0;
   dsm_net_master i_master (.clk_sys, .obj_rsp, .obj_req, .ctrl_valid, .ctrl_word,
      .mode_source_parameter);
   dsm_drive_objects i_dut (.clk_sys, .rst_b, .obj_req, .obj_rsp, .drive_state, .drive_cond,
      .mode_source_parameter, .ctrl_valid, .ctrl_word, .cmd_valid, .cmd_word(), .cmd_refused,
      .fault_reset_pulse, .state_word, .mode_active(), .increments_unit(), .resolution_turns(),
      .gear_motor_turns(), .gear_shaft_turns());
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // access, check code and data
   task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] wd, input logic [31:0] code, input logic [31:0] rd);
      dsm_pkg::dsm_obj_rsp_t r;
      i_master.access(wr, idx, sub, wd, r);
      chk({31'h0, r.ack}, 32'h1);
      chk(r.abort_code, code);
      chk(r.rdata, rd);
   endtask
   task automatic conclude();
      $display("TB: checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      #20000;
      n_fail++;
      conclude();
   end
   initial begin
      rst_b = 1'b0;
      drive_state = dsm_pkg::DSM_NOT_READY;
      drive_cond = '0;
      last = 8'h01;
      repeat (2) @(posedge clk_sys);
      #1;
      rst_b = 1'b1;
      @(posedge clk_sys);
      #1;
      for (int k = 0; k < 9; k++) acc(1'b0, IX[k], (k < 6) ? 8'(k % 3) : 8'h00, 32'h0, 32'h0, RV[k]);
      $display("TB: test reset_values done");
      for (int v = 0; v < 6; v++) begin
         ok = (v == 1 || v == 3 || v == 4);
         if (ok) last = 8'(v);
         acc(1'b1, 16'h6060, 8'h00, 32'(v), ok ? 32'h0 : `DSM_ABORT_RANGE, 32'h0);
         acc(1'b0, 16'h6061, 8'h00, 32'h0, 32'h0, {24'h0, last});
      end
      for (int k = 0; k < 5; k++) begin
         acc(1'b1, 16'h608F, 8'h01, UV[k], (k == 3) ? `DSM_ABORT_RANGE : 32'h0, 32'h0);
         acc(1'b0, 16'h608F, 8'h01, 32'h0, 32'h0, (k == 3) ? UV[2] : UV[k]);
      end
      for (int j = 0; j < 3; j++) begin
         acc(1'b1, j ? 16'h6091 : 16'h608F, (j == 1) ? 8'h01 : 8'h02, 32'h2, `DSM_ABORT_RANGE, 32'h0);
         acc(1'b0, j ? 16'h6091 : 16'h608F, (j == 1) ? 8'h01 : 8'h02, 32'h0, 32'h0, 32'h1);
      end
      acc(1'b1, 16'h6502, 8'h00, 32'h0, `DSM_ABORT_READ_ONLY, 32'h0);
      acc(1'b1, 16'h6091, 8'h00, 32'h3, `DSM_ABORT_READ_ONLY, 32'h0);
      acc(1'b1, 16'h6041, 8'h00, 32'h0, `DSM_ABORT_READ_ONLY, 32'h0);
      acc(1'b1, 16'h1234, 8'h00, 32'h0, `DSM_ABORT_NO_OBJECT, 32'h0);
      acc(1'b0, 16'h608F, 8'h03, 32'h0, `DSM_ABORT_NO_SUB, 32'h0);
      $display("TB: test object_writes done");
      for (int s = 0; s < 8; s++) begin
         drive_state = dsm_pkg::dsm_drive_state_t'(s);
         drive_cond = {s[0], s == 4, s == 1, 2'(s)};
         i_master.set_source(s[2]);
         sw = {2'b00, 2'(s), 1'b0, (s == 1 || s == 4 || s == 5), s[2], 2'b00, CODE[s][5:4], s[0], CODE[s][3:0]};
         @(posedge clk_sys);
         #1;
         chk({16'h0, state_word}, {16'h0, sw});
         acc(1'b0, 16'h6041, 8'h00, 32'h0, 32'h0, {16'h0, sw});
      end
      $display("TB: test state_word done");
      for (int c = 0; c < 3; c++) begin
         i_master.set_source(c != 0);
         i_master.send(c[0] ? 16'h0000 : 16'h0080);
         chk(32'({cmd_valid, cmd_refused, fault_reset_pulse}), (c == 0) ? 32'h2 : (c == 1) ? 32'h4 : 32'h5);
         @(posedge clk_sys);
         #1;
      end
      $display("TB: test control_word done");
      conclude();
   end
endmodule
`default_nettype wire
